// ===== hdl/rsrc_reset_ctrl.sv
// Reset and stop-mode recovery controller with supply warning and cause status.
// Assumes pins and supply comparators are asynchronous; watchdog and core strobes
// arrive on pclk.
//
// What this block does
// - Power-on and supply dropout both start a full system reset.
// - Watchdog timeout resets the system only when its reset option is set.
// - A low reset pin resets only while its reset alternate function is enabled.
// - Writing one to debugger control bit zero performs a system reset.
// - A watchdog timeout during stop mode starts stop recovery.
// - A transition on an enabled port input during stop starts recovery.
// - Stop recovery is its own reset kind, separate from full system reset.
// - Enabling the crystal oscillator lengthens the system reset hold.
// - A low reset pin during stop gives a full system reset.
// - Reset pin low pulses shorter than the filter width are ignored.
// - The supply warning bit follows the warning level and never latches.
// - Status reads and writes never change the supply warning bit.
// - A supply warning can raise an interrupt when enabled.
// - Disabling supply dropout reset also disables the supply warning.
// - Supply warning exists only in the small-package variant.
// - Status reports last reset cause, stop recovery and watchdog timeout.
// - Reading the status clears its upper four bits.
// - Status reads and watchdog control writes share one address.
// - The reset pin starts up in its reset alternate function.
// - Only port pins with their recovery enable set can start recovery.

`timescale 1ns/100ps
module rsrc_reset_ctrl #(
   parameter int PORT_W = 8,
   parameter bit HAS_LSW = 1'b1,
   parameter int FILTER_CYC = rsrc_pkg::PIN_FILTER_CYC
) (
   // Clock and power-on reset.
   input wire logic pclk,
   input wire logic presetn,

   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_ff,
   output logic pready_ff,
   output logic pslverr_ff,

   // Asynchronous supply comparators and reset pin.
   input wire rsrc_pkg::rsrc_supply_type supply_in,

   // Asynchronous port inputs watched as recovery sources.
   input wire logic [PORT_W-1:0] port_in,

   // Core and watchdog strobes on pclk.
   input wire logic stop_req,
   input wire logic wdt_timeout,

   // Reset and mode outputs.
   output logic sys_reset_n_ff,
   output logic recovery_ff,
   output logic stop_mode_ff,
   output logic pin_alt_reset_ff,
   output logic lsw_irq_ff,

   // Watchdog control written through the shared address.
   output logic [7:0] wdt_ctrl_ff,
   output logic wdt_ctrl_wr_ff
);
   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   localparam int SYNC_W = PORT_W + 3;
   localparam int FLT_W = $clog2(FILTER_CYC + 1);
   localparam logic [FLT_W-1:0] FLT_LAST = FLT_W'(FILTER_CYC);

   typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_STOP, ST_RECOVER} rsrc_state_type;

   rsrc_state_type state_ff;
   rsrc_state_type nxt_state;
   logic [rsrc_pkg::CNT_W-1:0] cnt_ff;
   logic [rsrc_pkg::CNT_W-1:0] nxt_cnt;

   logic [SYNC_W-1:0] sync1_ff;
   logic [SYNC_W-1:0] sync2_ff;
   logic [PORT_W-1:0] port_prev_ff;

   logic [FLT_W-1:0] flt_cnt_ff;
   logic [FLT_W-1:0] nxt_flt_cnt;

   rsrc_pkg::rsrc_cfg_type cfg_ff;
   logic [PORT_W-1:0] recov_en_ff;

   logic dbg_ff;
   logic lsw_ff;
   logic [5:0] cause_ff;
   logic [5:0] nxt_cause;
   logic [7:0] rd_val;

   // Address match, used by every decode below.
   function automatic logic addr_is(input logic [11:0] a, input logic [11:0] r);
      addr_is = (a == r);
   endfunction : addr_is

   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------
   // Only the second stage is read by the logic below.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_ff <= {3'b001, {PORT_W{1'b0}}};
         sync2_ff <= {3'b001, {PORT_W{1'b0}}};
      end else begin
         sync1_ff <= {supply_in, port_in};
         sync2_ff <= sync1_ff;
      end
   end

   wire logic [PORT_W-1:0] port_s = sync2_ff[PORT_W-1:0];
   wire logic pin_s = sync2_ff[PORT_W];
   wire logic warn_s = sync2_ff[PORT_W+1];
   wire logic drop_s = sync2_ff[PORT_W+2];

   // ----------------------------------------------------------------------
   // Reset pin glitch filter
   // ----------------------------------------------------------------------
   // The counter saturates so a long low keeps the request up; the pin reset
   // starts once the count reaches FILTER_CYC, so a pin held low from power-up is seen too.
   always_comb begin
      nxt_flt_cnt = flt_cnt_ff;
      if (pin_s) begin
         nxt_flt_cnt = '0;
      end else if (flt_cnt_ff != FLT_LAST) begin
         nxt_flt_cnt = flt_cnt_ff + FLT_W'(1);
      end
   end

   // Pin filter count.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flt_cnt_ff <= '0;
      end else begin
         flt_cnt_ff <= nxt_flt_cnt;
      end
   end

   // ----------------------------------------------------------------------
   // Reset and recovery requests
   // ----------------------------------------------------------------------
   wire logic pin_low_ok = (flt_cnt_ff == FLT_LAST);
   wire logic pin_rst = cfg_ff.pin_alt_en & pin_low_ok;
   wire logic drop_rst = cfg_ff.dropout_en & drop_s;
   wire logic dbg_rst = dbg_ff;
   wire logic wdt_rst = wdt_timeout & cfg_ff.wdt_rst_opt;
   wire logic hard_rst = drop_rst | pin_rst | dbg_rst;
   wire logic run_rst = hard_rst | wdt_rst;
   wire logic [PORT_W-1:0] port_edge = (port_s ^ port_prev_ff) & recov_en_ff;
   wire logic stop_wake = wdt_timeout | (|port_edge);
   wire logic [rsrc_pkg::CNT_W-1:0] hold_last = cfg_ff.xtal_en ?
      rsrc_pkg::RST_HOLD_CYC + rsrc_pkg::XTAL_EXTRA_CYC - 16'h0001 :
      rsrc_pkg::RST_HOLD_CYC - 16'h0001;

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   // A level source that stays asserted keeps restarting the hold count, so
   // the system is released only a full hold time after the last request.
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff + 16'h0001;
      case (state_ff)
         ST_HOLD: begin
            if (drop_rst | pin_rst) begin
               nxt_cnt = '0;
            end else if (cnt_ff >= hold_last) begin
               nxt_state = ST_RUN;
               nxt_cnt = '0;
            end
         end
         ST_RUN: begin
            nxt_cnt = '0;
            if (run_rst) begin
               nxt_state = ST_HOLD;
            end else if (stop_req) begin
               nxt_state = ST_STOP;
            end
         end
         ST_STOP: begin
            nxt_cnt = '0;
            if (hard_rst) begin
               nxt_state = ST_HOLD;
            end else if (stop_wake) begin
               nxt_state = ST_RECOVER;
            end
         end
         ST_RECOVER: begin
            if (run_rst) begin
               nxt_state = ST_HOLD;
               nxt_cnt = '0;
            end else if (cnt_ff >= rsrc_pkg::RECOV_CYC - 16'h0001) begin
               nxt_state = ST_RUN;
               nxt_cnt = '0;
            end
         end
         default: begin
            nxt_state = ST_HOLD;
            nxt_cnt = '0;
         end
      endcase
   end

   // Power-on enters the hold state straight from the asynchronous reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_HOLD;
         cnt_ff <= '0;
         port_prev_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         port_prev_ff <= port_s;
      end
   end

   // Outputs are registered copies of the next state, so they line up with it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_reset_n_ff <= 1'b0;
         recovery_ff <= 1'b0;
         stop_mode_ff <= 1'b0;
      end else begin
         sys_reset_n_ff <= (nxt_state != ST_HOLD);
         recovery_ff <= (nxt_state == ST_RECOVER);
         stop_mode_ff <= (nxt_state == ST_STOP);
      end
   end

   // ----------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------
   // One wait state: pready rises in the first access cycle, the transfer
   // completes at the next edge, where writes and read side effects act.
   wire logic acc_start = psel & penable & ~pready_ff;
   wire logic acc_done = psel & penable & pready_ff;
   wire logic hit_stat = addr_is(paddr, rsrc_pkg::ADDR_STATUS_WDT);
   wire logic hit_cfg = addr_is(paddr, rsrc_pkg::ADDR_CONFIG);
   wire logic hit_dbg = addr_is(paddr, rsrc_pkg::ADDR_DEBUG);
   wire logic hit_rec = addr_is(paddr, rsrc_pkg::ADDR_RECOV_EN);
   wire logic addr_ok = hit_stat | hit_cfg | hit_dbg | hit_rec;
   wire logic wr_done = acc_done & pwrite;
   wire logic stat_rd = acc_done & ~pwrite & hit_stat;
   wire logic [PORT_W-1:0] rec_rd = recov_en_ff;

   // Read data selection; the status value is sampled as pready rises.
   always_comb begin
      rd_val = 8'h00;
      if (hit_stat) begin
         rd_val = {cause_ff, 1'b0, lsw_ff};
      end else if (hit_cfg) begin
         rd_val = {3'h0, cfg_ff};
      end else if (hit_dbg) begin
         rd_val = {7'h00, dbg_ff};
      end else if (hit_rec) begin
         rd_val = 8'(rec_rd);
      end
   end

   // Bus answer flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         prdata_ff <= '0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= acc_start;
         prdata_ff <= (acc_start & ~pwrite) ? {24'h000000, rd_val} : 32'h00000000;
         pslverr_ff <= acc_start & ~addr_ok;
      end
   end

   // ----------------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------------
   // The pin starts in its reset function; software may hand it to GPIO.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff <= rsrc_pkg::CFG_RESET;
         recov_en_ff <= PORT_W'(rsrc_pkg::RECOV_EN_RESET);
      end else begin
         if (wr_done & hit_cfg) begin
            cfg_ff <= pwdata[4:0];
         end
         if (wr_done & hit_rec) begin
            recov_en_ff <= pwdata[PORT_W-1:0];
         end
      end
   end

   // The shared address stores watchdog control on writes only.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_ctrl_ff <= rsrc_pkg::WDT_CTRL_RESET;
         wdt_ctrl_wr_ff <= 1'b0;
      end else begin
         wdt_ctrl_wr_ff <= wr_done & hit_stat;
         if (wr_done & hit_stat) begin
            wdt_ctrl_ff <= pwdata[7:0];
         end
      end
   end

   // The debugger request stays until the hold state has taken it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dbg_ff <= 1'b0;
      end else begin
         dbg_ff <= (wr_done & hit_dbg & pwdata[rsrc_pkg::DBG_RESET_BIT]) |
                   (dbg_ff & (state_ff != ST_HOLD));
      end
   end

   // Pin mirror.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_alt_reset_ff <= 1'b1;
      end else begin
         pin_alt_reset_ff <= cfg_ff.pin_alt_en;
      end
   end

   // ----------------------------------------------------------------------
   // Supply warning
   // ----------------------------------------------------------------------
   // The bit only mirrors the comparator; a short dip is caught by the
   // interrupt pulse, not by polling.
   wire logic lsw_live = HAS_LSW & cfg_ff.dropout_en & warn_s;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lsw_ff <= 1'b0;
         lsw_irq_ff <= 1'b0;
      end else begin
         lsw_ff <= lsw_live;
         lsw_irq_ff <= lsw_live & ~lsw_ff & cfg_ff.lsw_irq_en;
      end
   end

   // ----------------------------------------------------------------------
   // Reset cause status
   // ----------------------------------------------------------------------
   // Bits 7..2 held here; a new reset or recovery overwrites the cause, a
   // read clears the top four, and a watchdog event in the same cycle as a read wins.
   wire logic rst_entry = (nxt_state == ST_HOLD) && (state_ff != ST_HOLD);
   wire logic rec_entry = (nxt_state == ST_RECOVER) && (state_ff == ST_STOP);
   wire logic [5:0] ev_cause = {1'b0, rec_entry, wdt_timeout & (rec_entry | ~hard_rst),
                                pin_rst, dbg_rst & ~pin_rst, drop_rst & ~pin_rst & ~dbg_rst};
   wire logic [5:0] kept = stat_rd ? {4'h0, cause_ff[1:0]} : cause_ff;

   always_comb begin
      nxt_cause = kept | {2'b00, wdt_timeout, 3'b000};
      if (rst_entry | rec_entry) begin
         nxt_cause = ev_cause;
      end
   end

   // Cause register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_ff <= rsrc_pkg::CAUSE_RESET;
      end else begin
         cause_ff <= nxt_cause;
      end
   end
endmodule : rsrc_reset_ctrl

// ===== pkg/rsrc_pkg.sv
// Constants, field layouts and carrier types of the reset and stop recovery controller.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
package rsrc_pkg;
   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [11:0] ADDR_STATUS_WDT = 12'h000;
   localparam logic [11:0] ADDR_CONFIG = 12'h004;
   localparam logic [11:0] ADDR_DEBUG = 12'h008;
   localparam logic [11:0] ADDR_RECOV_EN = 12'h00c;
   // Status byte field positions; the upper four clear on read.
   localparam int ST_POR_BIT = 7;
   localparam int ST_RECOV_BIT = 6;
   localparam int ST_WDT_BIT = 5;
   localparam int ST_PIN_BIT = 4;
   localparam int ST_DBG_BIT = 3;
   localparam int ST_DROP_BIT = 2;
   localparam int ST_LSW_BIT = 0;
   localparam int DBG_RESET_BIT = 0;
   // Reset values.
   localparam logic [5:0] CAUSE_RESET = 6'h20;
   localparam logic [4:0] CFG_RESET = 5'h0c;
   localparam logic [7:0] RECOV_EN_RESET = 8'h00;
   localparam logic [7:0] WDT_CTRL_RESET = 8'h00;
   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int RST_HOLD_NS = 1000;
   localparam int XTAL_EXTRA_NS = 5000;
   localparam int RECOV_NS = 200;
   localparam int PIN_FILTER_NS = 100;
   localparam int CNT_W = 16;
   // Least times, rounded up to whole cycles.
   localparam logic [CNT_W-1:0] RST_HOLD_CYC = CNT_W'((RST_HOLD_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] XTAL_EXTRA_CYC = CNT_W'((XTAL_EXTRA_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] RECOV_CYC = CNT_W'((RECOV_NS * CLK_MHZ + 999) / 1000);
   localparam int PIN_FILTER_CYC = (PIN_FILTER_NS * CLK_MHZ + 999) / 1000;
   // ----------------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic lsw_irq_en;
      logic pin_alt_en;
      logic dropout_en;
      logic xtal_en;
      logic wdt_rst_opt;
   } rsrc_cfg_type;
   typedef struct packed {
      logic supply_below_min;
      logic supply_below_warn;
      logic reset_pin;
   } rsrc_supply_type;
endpackage : rsrc_pkg

// ===== dv/rsrc_reset_ctrl_assertions.sv
// Port checker of the reset and stop recovery controller.
// Assumes a bind to rsrc_reset_ctrl with FILTER_CYC of four or less.
`timescale 1ns/100ps
module rsrc_reset_ctrl_chk #(
   parameter int PORT_W = 8
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready_ff,
   // Pins and strobes.
   input wire rsrc_pkg::rsrc_supply_type supply_in,
   input wire logic [PORT_W-1:0] port_in,
   input wire logic wdt_timeout,
   // Watched outputs.
   input wire logic sys_reset_n_ff,
   input wire logic recovery_ff,
   input wire logic stop_mode_ff,
   input wire logic pin_alt_reset_ff,
   input wire logic lsw_irq_ff
);
   // ------------------------------------------------------------
   // Shadow registers and length counters
   // ------------------------------------------------------------
   logic [4:0] cfg_ff;
   logic [PORT_W-1:0] ren_ff;
   logic [15:0] low_ff;
   logic [15:0] rec_ff;
   // Shadows follow completed writes, so a refused access must not move them.
   wire logic wr_done = psel && penable && pready_ff && pwrite;
   wire logic cfg_hit = wr_done && (paddr == rsrc_pkg::ADDR_CONFIG);
   wire logic ren_hit = wr_done && (paddr == rsrc_pkg::ADDR_RECOV_EN);
   wire logic [4:0] nxt_cfg = cfg_hit ? pwdata[4:0] : cfg_ff;
   wire logic [PORT_W-1:0] nxt_ren = ren_hit ? pwdata[PORT_W-1:0] : ren_ff;
   wire logic [15:0] xtra = cfg_ff[1] ? rsrc_pkg::XTAL_EXTRA_CYC : 16'h0000;
   wire logic [15:0] hold = rsrc_pkg::RST_HOLD_CYC + xtra;
   // Counters hold the run length of low reset and of recovery.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff <= rsrc_pkg::CFG_RESET;
         ren_ff <= '0;
         low_ff <= 16'h0000;
         rec_ff <= 16'h0000;
      end else begin
         cfg_ff <= nxt_cfg;
         ren_ff <= nxt_ren;
         low_ff <= sys_reset_n_ff ? 16'h0000 : low_ff + 16'h0001;
         rec_ff <= recovery_ff ? rec_ff + 16'h0001 : 16'h0000;
      end
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_dropout_rst: assert property ((supply_in.supply_below_min && cfg_ff[2])[*4]
      |=> !sys_reset_n_ff) else $error("dropout gave no reset");
   a_hold_len: assert property ($rose(sys_reset_n_ff) |-> low_ff >= hold)
      else $error("reset hold too short");
   a_wdt_rst: assert property (wdt_timeout && cfg_ff[0] && sys_reset_n_ff && !stop_mode_ff
      && !recovery_ff |-> ##[1:3] !sys_reset_n_ff) else $error("watchdog gave no reset");
   a_pin_rst: assert property ((!supply_in.reset_pin && pin_alt_reset_ff)[*8]
      |-> !sys_reset_n_ff) else $error("pin gave no reset");
   a_dbg_rst: assert property (wr_done && paddr == rsrc_pkg::ADDR_DEBUG && pwdata[0]
      |-> ##[1:4] !sys_reset_n_ff) else $error("debug gave no reset");
   a_wdt_wake: assert property (wdt_timeout && stop_mode_ff |-> ##[1:3] recovery_ff)
      else $error("watchdog gave no recovery");
   a_port_wake: assert property (stop_mode_ff && ((port_in ^ $past(port_in)) & ren_ff) != '0
      |-> ##[1:5] recovery_ff) else $error("port gave no recovery");
   a_recov_kind: assert property (recovery_ff |-> sys_reset_n_ff)
      else $error("reset during recovery");
   a_recov_len: assert property ($fell(recovery_ff) && sys_reset_n_ff
      |-> rec_ff == rsrc_pkg::RECOV_CYC) else $error("recovery length wrong");
   a_irq_pulse: assert property (lsw_irq_ff |=> !lsw_irq_ff)
      else $error("irq longer than a cycle");
   c_recov: cover property ($rose(recovery_ff));
   c_reset: cover property ($fell(sys_reset_n_ff));
   c_irq: cover property (lsw_irq_ff);
endmodule : rsrc_reset_ctrl_chk

bind rsrc_reset_ctrl rsrc_reset_ctrl_chk #(.PORT_W(PORT_W)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready_ff(pready_ff), .supply_in(supply_in),
   .port_in(port_in), .wdt_timeout(wdt_timeout), .sys_reset_n_ff(sys_reset_n_ff),
   .recovery_ff(recovery_ff), .stop_mode_ff(stop_mode_ff),
   .pin_alt_reset_ff(pin_alt_reset_ff), .lsw_irq_ff(lsw_irq_ff));

// ===== dv/tb.sv
// Self-checking bench of the reset and stop recovery controller.
// Assumes the port checker is bound and the pin filter is set to two cycles.
`timescale 1ns/100ps
module tb;
   // ------------------------------------------------------------
   // Signals, rows and counters
   // ------------------------------------------------------------
   typedef struct packed {
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] q;
      logic e;
   } rsrc_row_type;
   rsrc_row_type rows [4];
   logic pclk, presetn, psel, penable, pwrite, stop_req, wdt_timeout;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata_ff, rd;
   logic pready_ff, pslverr_ff, err, sys_reset_n_ff, recovery_ff, stop_mode_ff;
   logic pin_alt_reset_ff, lsw_irq_ff, wdt_ctrl_wr_ff;
   logic [7:0] port_in, wdt_ctrl_ff;
   rsrc_pkg::rsrc_supply_type supply_in;
   int failures = 0;
   int n_checks = 0;
   int cyc = 0;
   int irqs = 0;
   int n, i, r;
   // A short filter keeps the glitch cases brief.
   rsrc_reset_ctrl #(.FILTER_CYC(2)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
      .pslverr_ff(pslverr_ff), .supply_in(supply_in), .port_in(port_in),
      .stop_req(stop_req), .wdt_timeout(wdt_timeout), .sys_reset_n_ff(sys_reset_n_ff),
      .recovery_ff(recovery_ff), .stop_mode_ff(stop_mode_ff),
      .pin_alt_reset_ff(pin_alt_reset_ff), .lsw_irq_ff(lsw_irq_ff),
      .wdt_ctrl_ff(wdt_ctrl_ff), .wdt_ctrl_wr_ff(wdt_ctrl_wr_ff));
   // Clock of 100 MHz.
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Hang ceiling and warning irq count.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (lsw_irq_ff === 1'b1) irqs <= irqs + 1;
      if (cyc == 20000) begin
         failures = failures + 1;
         report_and_stop();
      end
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Request holds until pready is seen at an edge.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite} <= {1'b1, 1'b0, w};
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (i = 0; pready_ff !== 1'b1; i++) @(posedge pclk);
      rd = prdata_ff;
      err = pslverr_ff;
      {psel, penable} <= 2'b00;
   endtask : apb
   task rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, what);
   endtask : rd_chk
   task wait_rst();
      for (i = 0; sys_reset_n_ff !== 1'b0; i++) @(posedge pclk);
      for (n = 0; sys_reset_n_ff !== 1'b1; n++) @(posedge pclk);
   endtask : wait_rst
   task wait_rec(input logic v);
      for (i = 0; recovery_ff !== v; i++) @(posedge pclk);
   endtask : wait_rec
   task strobe(input logic wd);
      @(posedge pclk);
      if (wd) wdt_timeout <= 1'b1;
      else stop_req <= 1'b1;
      @(posedge pclk);
      {wdt_timeout, stop_req} <= 2'b00;
   endtask : strobe
   task report_and_stop();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, stop_req, wdt_timeout} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      supply_in = 3'b001;
      port_in = 8'h00;
      rows[0] = {rsrc_pkg::ADDR_RECOV_EN, 32'hffffff5a, 32'h5a, 1'b0};
      rows[1] = {rsrc_pkg::ADDR_CONFIG, 32'h1c, 32'h1c, 1'b0};
      rows[2] = {12'h010, 32'h77, 32'h0, 1'b1};
      rows[3] = {12'hffc, 32'h1, 32'h0, 1'b1};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      wait_rst();
      chk(32'(n >= 100), 32'h1, "hold");
      rd_chk(rsrc_pkg::ADDR_STATUS_WDT, 32'h80, "por");
      rd_chk(rsrc_pkg::ADDR_STATUS_WDT, 32'h0, "cleared");
      rd_chk(rsrc_pkg::ADDR_CONFIG, 32'h0c, "cfg");
      $display("reset test done");
      for (r = 0; r < 4; r++) begin
         apb(1'b1, rows[r].a, rows[r].d);
         rd_chk(rows[r].a, rows[r].q, "row");
         chk(32'(err), 32'(rows[r].e), "row err");
      end
      apb(1'b1, rsrc_pkg::ADDR_STATUS_WDT, 32'h1a5);
      #1;
      chk(32'(wdt_ctrl_ff), 32'ha5, "wdt ctrl");
      chk(32'(wdt_ctrl_wr_ff), 32'h1, "wdt wr");
      rd_chk(rsrc_pkg::ADDR_STATUS_WDT, 32'h0, "shared");
      $display("register test done");
      supply_in.supply_below_warn <= 1'b1;
      repeat (6) @(posedge pclk);
      rd_chk(rsrc_pkg::ADDR_STATUS_WDT, 32'h1, "warn");
      apb(1'b1, rsrc_pkg::ADDR_STATUS_WDT, 32'h0);
      rd_chk(rsrc_pkg::ADDR_STATUS_WDT, 32'h1, "warn kept");
      chk(irqs, 32'h1, "irq");
      supply_in.supply_below_warn <= 1'b0;
      repeat (6) @(posedge pclk);
      rd_chk(rsrc_pkg::ADDR_STATUS_WDT, 32'h0, "warn gone");
      apb(1'b1, rsrc_pkg::ADDR_CONFIG, 32'h18);
      supply_in.supply_below_warn <= 1'b1;
      repeat (6) @(posedge pclk);
      rd_chk(rsrc_pkg::ADDR_STATUS_WDT, 32'h0, "warn off");
      chk(irqs, 32'h1, "no irq");
      supply_in.supply_below_warn <= 1'b0;
      repeat (6) @(posedge pclk);
      apb(1'b1, rsrc_pkg::ADDR_CONFIG, 32'h1c);
      strobe(1'b1);
      repeat (10) @(posedge pclk);
      chk(32'(sys_reset_n_ff), 32'h1, "wdt no rst");
      rd_chk(rsrc_pkg::ADDR_STATUS_WDT, 32'h20, "wdt flag");
      $display("warning test done");
      apb(1'b1, rsrc_pkg::ADDR_CONFIG, 32'h1d);
      strobe(1'b1);
      wait_rst();
      rd_chk(rsrc_pkg::ADDR_STATUS_WDT, 32'h20, "wdt cause");
      apb(1'b1, rsrc_pkg::ADDR_DEBUG, 32'h1);
      wait_rst();
      rd_chk(rsrc_pkg::ADDR_STATUS_WDT, 32'h08, "dbg cause");
      supply_in.supply_below_min <= 1'b1;
      repeat (5) @(posedge pclk);
      supply_in.supply_below_min <= 1'b0;
      wait_rst();
      rd_chk(rsrc_pkg::ADDR_STATUS_WDT, 32'h04, "drop cause");
      supply_in.reset_pin <= 1'b0;
      repeat (8) @(posedge pclk);
      supply_in.reset_pin <= 1'b1;
      wait_rst();
      rd_chk(rsrc_pkg::ADDR_STATUS_WDT, 32'h10, "pin cause");
      supply_in.reset_pin <= 1'b0;
      @(posedge pclk);
      supply_in.reset_pin <= 1'b1;
      repeat (12) @(posedge pclk);
      chk(32'(sys_reset_n_ff), 32'h1, "glitch");
      apb(1'b1, rsrc_pkg::ADDR_CONFIG, 32'h15);
      supply_in.reset_pin <= 1'b0;
      repeat (12) @(posedge pclk);
      chk(32'(pin_alt_reset_ff), 32'h0, "alt off");
      chk(32'(sys_reset_n_ff), 32'h1, "pin off");
      supply_in.reset_pin <= 1'b1;
      apb(1'b1, rsrc_pkg::ADDR_CONFIG, 32'h1f);
      apb(1'b1, rsrc_pkg::ADDR_DEBUG, 32'h1);
      wait_rst();
      chk(32'(n >= 600), 32'h1, "xtal hold");
      apb(1'b1, rsrc_pkg::ADDR_CONFIG, 32'h1d);
      $display("cause test done");
      strobe(1'b0);
      port_in <= 8'h01;
      repeat (8) @(posedge pclk);
      chk(32'(stop_mode_ff), 32'h1, "masked");
      port_in <= 8'h03;
      wait_rec(1'b1);
      chk(32'(recovery_ff), 32'h1, "port wake");
      chk(32'(sys_reset_n_ff), 32'h1, "no rst");
      wait_rec(1'b0);
      rd_chk(rsrc_pkg::ADDR_STATUS_WDT, 32'h40, "recov");
      strobe(1'b0);
      strobe(1'b1);
      wait_rec(1'b1);
      chk(32'(recovery_ff & sys_reset_n_ff), 32'h1, "wdt wake");
      wait_rec(1'b0);
      rd_chk(rsrc_pkg::ADDR_STATUS_WDT, 32'h60, "wdt recov");
      strobe(1'b0);
      supply_in.reset_pin <= 1'b0;
      repeat (8) @(posedge pclk);
      supply_in.reset_pin <= 1'b1;
      chk(32'(recovery_ff), 32'h0, "pin stop");
      wait_rst();
      chk(32'(n >= 100), 32'h1, "full");
      rd_chk(rsrc_pkg::ADDR_STATUS_WDT, 32'h10, "pin stop");
      $display("stop test done");
      report_and_stop();
   end
endmodule : tb
